// ==== bench/hsp_conv_model.sv ====
// Model of the four A/D converters and the D/A output stage.
// Assumes the bench sets sample levels and pacing: 0 prompt, 1 slow, 2 stalled.
`default_nettype none
module hsp_conv_model
  import hsp_pkg::*;
(
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  // Bench control
  input  wire hsp_adc_s   i_smp,
  input  wire logic [1:0] i_pace,
  // Device side
  output hsp_adc_s        o_adc,
  input  wire logic       i_dac_valid,
  output logic            o_dac_ready,
  input  wire hsp_smp_t   i_dac_data,
  // Received stream
  output hsp_smp_t        o_last,
  output int              o_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rdy_r;

  assign o_adc = i_smp;
  assign o_dac_ready = rdy_r & i_rstn;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdy_r <= 1'b0;
    end else begin
      rdy_r <= (i_pace == 2'd0) || (i_pace == 2'd1 && $urandom_range(1) == 1);
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_last <= '0;
      o_cnt  <= 0;
    end else if (i_dac_valid && o_dac_ready) begin
      o_last <= i_dac_data;
      o_cnt  <= o_cnt + 1;
    end
  end
endmodule // hsp_conv_model
`default_nettype wire

// ==== bench/hsp_signal_path_bench.sv ====
// Self-checking bench of the hearing audio signal path.
// Assumes package, design, converter model and checker compiled before.
`default_nettype none
module hsp_signal_path_bench
  import hsp_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic         i_sys_clk = 1'b0;
  logic         i_rstn    = 1'b0;
  hsp_cfg_s     cfg, base;
  hsp_coef_wr_s coef = '0;
  hsp_adc_s     adc, smp = '0;
  logic         dac_valid, dac_ready, overrun;
  hsp_smp_t     dac_data, last;
  logic [1:0]   pace = 2'd0;
  int           cnt, error_cnt = 0, num_checks = 0;

  always #25 i_sys_clk = ~i_sys_clk;

  hsp_signal_path #(.FIFO_DEPTH(4)) u_dut (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_cfg(cfg), .i_coef(coef), .i_adc(adc),
    .o_dac_valid(dac_valid), .i_dac_ready(dac_ready), .o_dac_data(dac_data), .o_overrun(overrun));
  hsp_conv_model u_model (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_smp(smp), .i_pace(pace), .o_adc(adc),
    .i_dac_valid(dac_valid), .o_dac_ready(dac_ready), .i_dac_data(dac_data), .o_last(last), .o_cnt(cnt));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input hsp_smp_t seen, input hsp_smp_t exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_smp(input int n);
    int c0 = cnt;
    int t = 0;
    while (cnt < c0 + n && t < 3000 * n) begin
      @(negedge i_sys_clk);
      t++;
    end
    if (t >= 3000 * n) begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic set_coefs(input int lo, input int hi, input hsp_coef_t d);
    for (int ad = lo; ad <= hi; ad++) begin
      coef = '{1'b1, 8'(ad), d};
      @(negedge i_sys_clk);
    end
    coef.we = 1'b0;
    @(negedge i_sys_clk);
  endtask
  function automatic hsp_adc_s rnd_adc();
    return '{16'($urandom_range(16'h3fff)) - 16'h2000, 16'($urandom_range(16'h3fff)) - 16'h2000,
             16'($urandom_range(16'h3fff)) - 16'h2000, 16'($urandom_range(16'h3fff)) - 16'h2000};
  endfunction
  function automatic hsp_smp_t exp_out(input hsp_cfg_s c, input hsp_adc_s a, input int k, input int sh);
    logic signed [31:0] f, s, x, cl;
    f = 32'(a.front) <<< 4;
    case (c.src)
      HSP_SRC_COIL: s = 32'(a.coil) <<< 4;
      HSP_SRC_DAI:  s = 32'(a.direct_audio_input) <<< 4;
      default:      s = 32'(a.rear) <<< 4;
    endcase
    s = (k < 2) ? s >>> 1 : s;
    if (c.mode == HSP_MODE_MIX && c.sec_trim == 16'h2000) s = s >>> 1;
    if (c.mode == HSP_MODE_DIR && c.dir_beta == 16'h2000) s = s >>> 1;
    case (c.mode)
      HSP_MODE_MIX: x = f + s;
      HSP_MODE_DIR: x = f - s;
      default:      x = f;
    endcase
    x = x >>> (sh + int'(k >= 2 && k < 10));
    cl = 32'(c.clip_level);
    x = (x > cl) ? cl : (x < -cl) ? -cl : x;
    return x[19:0];
  endfunction
  task automatic run(input hsp_cfg_s c, input hsp_adc_s a, input int k, input int sh);
    if (k < 10) set_coefs(5 * k, 5 * k, 16'h2000);
    cfg = c;
    smp = a;
    wait_smp(3);
    check(last, exp_out(c, a, k, sh));
    if (k < 10) set_coefs(5 * k, 5 * k, 16'h4000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hsp_cfg_s c;
    hsp_adc_s a;
    int t, ov, c0;
    base = '{1'b0, HSP_SRC_REAR, HSP_MODE_OMNI, 4'h1, 16'h4000, 16'h4000, 16'h4000, 16'h4000,
             16'h4000, 20'h7ffff, 20'h7ffff, 20'h80000, 1'b0, 1'b0, 4'h0};
    cfg = base;
    void'($urandom(61));
    repeat (6) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    for (int i = 0; i < 14; i++) begin
      c = base;
      c.mode = hsp_mode_e'($urandom_range(4));
      c.src = hsp_src_e'($urandom_range(2));
      c.wb_gain = $urandom_range(1) ? 16'h2000 : 16'h4000;
      c.volume = $urandom_range(1) ? 16'h2000 : 16'h4000;
      c.sec_trim = $urandom_range(1) ? 16'h2000 : 16'h4000;
      c.dir_beta = $urandom_range(1) ? 16'h2000 : 16'h4000;
      c.clip_level = 20'($urandom_range(20'h7ffff, 20'h100));
      a = rnd_adc();
      if (c.mode > HSP_MODE_DIR) begin
        a.rear = '0;
        a.coil = '0;
        a.direct_audio_input = '0;
      end
      pace = 2'(i % 2);
      run(c, a, $urandom_range(10), int'(c.wb_gain == 16'h2000) + int'(c.volume == 16'h2000));
    end
    $display("test random paths done");
    pace = 2'd0;
    a = rnd_adc();
    set_coefs(64, 255, 16'h2000);
    run(base, a, 10, 1);
    c = base;
    c.nr_floor = 20'h7ffff;
    run(c, a, 10, 2);
    set_coefs(64, 255, 16'h4000);
    $display("test band gains done");
    a.front = 16'h1000;
    for (int n = 0; n < 5; n++) begin
      c = base;
      c.num_ch = 4'(n == 0 ? 1 : 2 * n);
      c.comp_thresh = (n == 0) ? 20'h0 : 20'h7ffff;
      run(c, a, 10, int'(n == 0));
    end
    $display("test compression done");
    set_coefs(50, 50, 16'h0000);
    for (int p = 0; p < 2; p++) begin
      c = base;
      c.noise_en = 1'b1;
      c.noise_post = p[0];
      run(c, a, 10, 0);
    end
    set_coefs(50, 50, 16'h4000);
    $display("test noise done");
    for (int r = 0; r < 2; r++) begin
      c = base;
      c.rate_16k = r[0];
      cfg = c;
      wait_smp(4);
      c0 = cnt;
      t = 0;
      while (cnt == c0 && t < 3000) begin
        @(negedge i_sys_clk);
        t++;
      end
      check(20'(t), r ? 20'd1250 : 20'd625);
    end
    $display("test rates done");
    cfg = base;
    wait_smp(2);
    pace = 2'd2;
    ov = 0;
    repeat (12 * 625) begin
      @(negedge i_sys_clk);
      ov += int'(overrun === 1'b1);
    end
    check(20'(ov > 0), 20'h1);
    pace = 2'd0;
    c0 = cnt;
    repeat (40) @(negedge i_sys_clk);
    check(20'(cnt - c0 >= 4), 20'h1);
    check(last, exp_out(base, a, 10, 0));
    $display("test stall done");
    end_sim();
  end
endmodule // hsp_signal_path_bench
`default_nettype wire

// ==== bench/hsp_signal_path_chk.sv ====
// Checker of the hearing audio signal path D/A stream.
// Assumes hsp_pkg compiled first; bound to every hsp_signal_path.
`default_nettype none
module hsp_signal_path_chk
  import hsp_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic         i_sys_clk,
  input wire logic         i_rstn,
  // Design inputs
  input wire hsp_cfg_s     i_cfg,
  input wire hsp_coef_wr_s i_coef,
  input wire hsp_adc_s     i_adc,
  input wire logic         i_dac_ready,
  // Design outputs
  input wire logic         o_dac_valid,
  input wire hsp_smp_t     o_dac_data,
  input wire logic         o_overrun
);
  timeunit 1ns;
  timeprecision 1ps;
  hsp_cfg_s    cfg_r;
  logic [11:0] cfg_age_r, rdy_age_r, low_age_r, gap_r;
  logic        steady;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_r     <= '0;
      cfg_age_r <= '0;
    end else begin
      cfg_r     <= i_cfg;
      cfg_age_r <= (i_cfg != cfg_r) ? 12'h0 : cfg_age_r + 12'(cfg_age_r != 12'hfff);
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdy_age_r <= '0;
      low_age_r <= '0;
    end else begin
      rdy_age_r <= i_dac_ready ? rdy_age_r + 12'(rdy_age_r != 12'hfff) : 12'h0;
      low_age_r <= i_dac_ready ? 12'h0 : low_age_r + 12'(low_age_r != 12'hfff);
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gap_r <= '0;
    end else begin
      gap_r <= (o_dac_valid && i_dac_ready) ? 12'h0 : gap_r + 12'(gap_r != 12'hfff);
    end
  end
  assign steady = (cfg_age_r == 12'hfff) && (rdy_age_r == 12'hfff);

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_hs;
    o_dac_valid && i_dac_ready;
  endsequence
  sequence s_quiet;
    !o_dac_valid [*8];
  endsequence

  property p_rst;
    !$past(i_rstn) |-> !o_dac_valid && (o_dac_data == '0) && !o_overrun;
  endproperty
  property p_hold;
    o_dac_valid && !i_dac_ready |=> o_dac_valid && $stable(o_dac_data);
  endproperty
  property p_fall;
    $fell(o_dac_valid) |-> $past(i_dac_ready);
  endproperty
  property p_ov_pulse;
    o_overrun |=> !o_overrun;
  endproperty
  property p_ov_stall;
    o_overrun |-> low_age_r >= 12'd600;
  endproperty
  property p_clip;
    o_dac_valid && (cfg_age_r == 12'hfff) |-> ($signed(o_dac_data) <= $signed(i_cfg.clip_level))
      && ($signed(o_dac_data) >= -$signed(i_cfg.clip_level));
  endproperty
  property p_rate;
    s_hs ##0 steady |-> gap_r == (i_cfg.rate_16k ? 12'd1249 : 12'd624);
  endproperty
  property p_quiet;
    s_hs ##0 steady |=> s_quiet;
  endproperty

  a_rst: assert property (p_rst) else $error("output not quiet after reset");
  a_hold: assert property (p_hold) else $error("sample changed while stalled");
  a_fall: assert property (p_fall) else $error("valid dropped without ready");
  a_ov_pulse: assert property (p_ov_pulse) else $error("overrun longer than one cycle");
  a_ov_stall: assert property (p_ov_stall) else $error("overrun without a stall");
  a_clip: assert property (p_clip) else $error("sample beyond clip level");
  a_rate: assert property (p_rate) else $error("sample spacing wrong");
  a_quiet: assert property (p_quiet) else $error("second sample too early");
endmodule // hsp_signal_path_chk

bind hsp_signal_path hsp_signal_path_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .i_sys_clk  (i_sys_clk),
  .i_rstn     (i_rstn),
  .i_cfg      (i_cfg),
  .i_coef     (i_coef),
  .i_adc      (i_adc),
  .i_dac_ready(i_dac_ready),
  .o_dac_valid(o_dac_valid),
  .o_dac_data (o_dac_data),
  .o_overrun  (o_overrun)
);
`default_nettype wire

// ==== hdl/hsp_defs.svh ====
// Constants of the hearing audio signal path: rates, widths, coefficient map.
// Included by the package and by the design file; definitions only.
`ifndef HSP_DEFS_SVH
`define HSP_DEFS_SVH
`define HSP_SYS_CLK_HZ   20000000
`define HSP_FS_HI_HZ     32000
`define HSP_FS_LO_HZ     16000
`define HSP_DIV_HI       (`HSP_SYS_CLK_HZ / `HSP_FS_HI_HZ)
`define HSP_DIV_LO       (`HSP_SYS_CLK_HZ / `HSP_FS_LO_HZ)
`define HSP_DIV_W        11
`define HSP_SMP_W        20
`define HSP_ADC_W        16
`define HSP_COEF_W       16
`define HSP_Q_SHIFT      14
`define HSP_UNITY        16'h4000
`define HSP_NUM_BQ       11
`define HSP_NOISE_BQ     4'ha
`define HSP_COEF_PER_BQ  5
`define HSP_SHAPE_BASE   8'h40
`define HSP_NUM_SHAPE    16
`define HSP_NR_BASE      8'h80
`define HSP_NUM_NR       128
`define HSP_MAX_CH       8
`define HSP_SMP_POS      20'h7ffff
`define HSP_SMP_NEG      20'h80000
`define HSP_ENV_DECAY    6
`define HSP_BETA_STEP    16'h0010
`define HSP_LFSR_SEED    20'h00001
`endif

// ==== hdl/hsp_pkg.sv ====
// Types of the hearing audio signal path.
// Assumes hsp_defs.svh on the include path.
`default_nettype none
package hsp_pkg;
  `include "hsp_defs.svh"

  typedef logic signed [`HSP_SMP_W-1:0]  hsp_smp_t;
  typedef logic signed [`HSP_COEF_W-1:0] hsp_coef_t;
  typedef logic signed [`HSP_ADC_W-1:0]  hsp_adc_t;

  typedef enum logic [1:0] {HSP_SRC_REAR, HSP_SRC_COIL, HSP_SRC_DAI} hsp_src_e;
  typedef enum logic [2:0] {HSP_MODE_OMNI, HSP_MODE_MIX, HSP_MODE_DIR, HSP_MODE_ADAPT,
                            HSP_MODE_CLASSIFY} hsp_mode_e;
  typedef enum logic [2:0] {ST_IDLE, ST_BQ, ST_COMB, ST_CHAN, ST_GAIN, ST_VOL, ST_CLIP,
                            ST_PUSH} hsp_state_e;

  typedef struct packed {
    hsp_adc_t front;
    hsp_adc_t rear;
    hsp_adc_t coil;
    hsp_adc_t direct_audio_input;
  } hsp_adc_s;

  typedef struct packed {
    logic       rate_16k;
    hsp_src_e   src;
    hsp_mode_e  mode;
    logic [3:0] num_ch;
    hsp_coef_t  dir_beta;
    hsp_coef_t  mic_trim;
    hsp_coef_t  sec_trim;
    hsp_coef_t  wb_gain;
    hsp_coef_t  volume;
    hsp_smp_t   clip_level;
    hsp_smp_t   comp_thresh;
    hsp_smp_t   nr_floor;
    logic       noise_en;
    logic       noise_post;
    logic [3:0] noise_shift;
  } hsp_cfg_s;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    hsp_coef_t  data;
  } hsp_coef_wr_s;
endpackage
`default_nettype wire

// ==== hdl/hsp_signal_path.sv ====
// Hearing audio signal path: input mux, directional combiner, biquads,
// channel processing, output gain, noise injection, clipper, output FIFO.
// Assumes A/D samples and configuration synchronous to i_sys_clk.
`default_nettype none
`include "hsp_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module hsp_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire  logic             i_sys_clk,
  input  wire  logic             i_rstn,
  // Fill side
  input  wire  logic             i_in_valid,
  output logic                   o_in_ready,
  input  wire  logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                   o_out_valid,
  input  wire  logic             i_out_ready,
  output logic [WIDTH-1:0]       o_out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_size
    $error("hsp_fifo: bad size");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  logic             push;
  logic             pop;

  assign o_in_ready  = (wr_r[AW] == rd_r[AW]) || (wr_r[AW-1:0] != rd_r[AW-1:0]);
  assign o_out_valid = (wr_r != rd_r);
  assign o_out_data  = mem_r[rd_r[AW-1:0]];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop) rd_r <= rd_r + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (push) mem_r[wr_r[AW-1:0]] <= i_in_data;
  end
endmodule // hsp_fifo

////////////////////////////////////////////////////////////////////////////////
module hsp_signal_path
  import hsp_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input  wire  logic         i_sys_clk,
  input  wire  logic         i_rstn,
  // Configuration and coefficient load
  input  wire  hsp_cfg_s     i_cfg,
  input  wire  hsp_coef_wr_s i_coef,
  // A/D samples
  input  wire  hsp_adc_s     i_adc,
  // D/A stream
  output logic               o_dac_valid,
  input  wire  logic         i_dac_ready,
  output hsp_smp_t           o_dac_data,
  // Status
  output logic               o_overrun
);
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("hsp_signal_path: FIFO_DEPTH must be a power of two from 2");
  end

  function automatic hsp_smp_t sat(input logic signed [39:0] v);
    if (v > 40'sh000007ffff) return `HSP_SMP_POS;
    if (v < -40'sh0000080000) return `HSP_SMP_NEG;
    return v[`HSP_SMP_W-1:0];
  endfunction

  function automatic hsp_smp_t mulq(input hsp_smp_t x, input hsp_coef_t g);
    logic signed [39:0] p;
    p = (40'(x) * 40'(g)) >>> `HSP_Q_SHIFT;
    return sat(p);
  endfunction

  function automatic hsp_smp_t widen(input hsp_adc_t a);
    return {a, 4'h0};
  endfunction

  hsp_state_e       st_r;
  logic [3:0]       bq_idx_r;
  logic [`HSP_DIV_W-1:0] div_r;
  logic             tick;
  logic             pend_r;
  logic             take;
  hsp_smp_t         acc_r;
  hsp_smp_t         front_r;
  hsp_smp_t         nse_r;
  logic [19:0]      lfsr_r;
  hsp_coef_t        beta_r;
  logic [6:0]       band_r;
  hsp_coef_t        coef_r [256];
  hsp_smp_t         bq_x1 [`HSP_NUM_BQ];
  hsp_smp_t         bq_x2 [`HSP_NUM_BQ];
  hsp_smp_t         bq_y1 [`HSP_NUM_BQ];
  hsp_smp_t         bq_y2 [`HSP_NUM_BQ];
  hsp_smp_t         env_r [`HSP_MAX_CH];
  logic             fifo_rdy;
  logic             fifo_vld;
  hsp_smp_t         fifo_dat;
  logic             fifo_pop;
  logic             dac_valid_r;
  hsp_smp_t         dac_data_r;
  logic             overrun_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sample rate divider
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_r <= '0;
    end else if (tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  assign tick = i_cfg.rate_16k ? (div_r >= `HSP_DIV_W'(`HSP_DIV_LO - 1))
                               : (div_r >= `HSP_DIV_W'(`HSP_DIV_HI - 1));
  assign take = (st_r == ST_IDLE) && pend_r;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pend_r    <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      pend_r    <= tick || (pend_r && !take);
      overrun_r <= tick && pend_r && !take;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coefficient and band gain store
  for (genvar gi = 0; gi < 256; gi++) begin : g_coef
    localparam logic RST_ONE = (gi < `HSP_NUM_BQ * `HSP_COEF_PER_BQ && gi % `HSP_COEF_PER_BQ == 0) ||
                               (gi >= 64 && gi < 64 + `HSP_NUM_SHAPE) || (gi >= 128);
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        coef_r[gi] <= RST_ONE ? `HSP_UNITY : 16'h0000;
      end else if (i_coef.we && i_coef.addr == 8'(gi)) begin
        coef_r[gi] <= i_coef.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared biquad engine
  logic [7:0]         cb;
  hsp_smp_t           bq_x;
  logic signed [39:0] bq_sum;
  hsp_smp_t           bq_out;

  always_comb begin
    cb     = {4'h0, bq_idx_r} * 8'h05;
    bq_x   = (bq_idx_r == `HSP_NOISE_BQ) ? hsp_smp_t'(lfsr_r) : acc_r;
    bq_sum = 40'(bq_x) * 40'(coef_r[cb]) + 40'(bq_x1[bq_idx_r]) * 40'(coef_r[cb + 8'h01])
           + 40'(bq_x2[bq_idx_r]) * 40'(coef_r[cb + 8'h02])
           - 40'(bq_y1[bq_idx_r]) * 40'(coef_r[cb + 8'h03])
           - 40'(bq_y2[bq_idx_r]) * 40'(coef_r[cb + 8'h04]);
    bq_out = sat(bq_sum >>> `HSP_Q_SHIFT);
  end

  for (genvar k = 0; k < `HSP_NUM_BQ; k++) begin : g_bq
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        bq_x1[k] <= '0;
        bq_x2[k] <= '0;
        bq_y1[k] <= '0;
        bq_y2[k] <= '0;
      end else if (st_r == ST_BQ && bq_idx_r == 4'(k)) begin
        bq_x1[k] <= bq_x;
        bq_x2[k] <= bq_x1[k];
        bq_y1[k] <= bq_out;
        bq_y2[k] <= bq_y1[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input selection and directional combiner
  hsp_smp_t  sec_in;
  hsp_coef_t beta_use;
  hsp_smp_t  comb_v;
  logic      adaptive;

  always_comb begin
    unique case (i_cfg.src)
      HSP_SRC_COIL: sec_in = widen(i_adc.coil);
      HSP_SRC_DAI:  sec_in = widen(i_adc.direct_audio_input);
      default:      sec_in = widen(i_adc.rear);
    endcase
    adaptive = (i_cfg.mode == HSP_MODE_ADAPT) || (i_cfg.mode == HSP_MODE_CLASSIFY);
    beta_use = adaptive ? beta_r : i_cfg.dir_beta;
    case (i_cfg.mode)
      HSP_MODE_OMNI:  comb_v = front_r;
      HSP_MODE_MIX:   comb_v = sat(40'(mulq(front_r, i_cfg.mic_trim)) + 40'(mulq(acc_r, i_cfg.sec_trim)));
      HSP_MODE_DIR, HSP_MODE_ADAPT, HSP_MODE_CLASSIFY:
                      comb_v = sat(40'(front_r) - 40'(mulq(acc_r, beta_use)));
      default:        comb_v = front_r;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      beta_r <= 16'h0000;
    end else if (st_r == ST_COMB && adaptive) begin
      if (comb_v[`HSP_SMP_W-1] == acc_r[`HSP_SMP_W-1]) begin
        if (beta_r < `HSP_UNITY) beta_r <= beta_r + `HSP_BETA_STEP;
      end else if (beta_r > 16'sh0000) begin
        beta_r <= beta_r - `HSP_BETA_STEP;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel processing: shaping bands, noise reduction, compression
  logic [3:0] nch;
  logic [7:0] chm;
  logic [2:0] ch;
  hsp_smp_t   abs_acc;
  hsp_smp_t   t_shape;
  hsp_smp_t   t_nr;
  hsp_smp_t   chan_v;

  always_comb begin
    case (i_cfg.num_ch)
      4'h1, 4'h2, 4'h4, 4'h6, 4'h8: nch = i_cfg.num_ch;
      default:                      nch = 4'h1;
    endcase
    chm     = {4'h0, band_r[6:3]} * {4'h0, nch};
    ch      = chm[6:4];
    abs_acc = acc_r[`HSP_SMP_W-1] ? -acc_r : acc_r;
    t_shape = mulq(acc_r, coef_r[`HSP_SHAPE_BASE + {4'h0, band_r[6:3]}]);
    t_nr    = (env_r[ch] < i_cfg.nr_floor) ? mulq(t_shape, coef_r[`HSP_NR_BASE + {1'b0, band_r}]) : t_shape;
    chan_v  = (env_r[ch] > i_cfg.comp_thresh) ? (t_nr >>> 1) : t_nr;
  end

  for (genvar c = 0; c < `HSP_MAX_CH; c++) begin : g_env
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        env_r[c] <= '0;
      end else if (st_r == ST_CHAN && ch == 3'(c)) begin
        env_r[c] <= (abs_acc > env_r[c]) ? abs_acc : env_r[c] - (env_r[c] >>> `HSP_ENV_DECAY);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      band_r <= '0;
    end else if (st_r == ST_CHAN) begin
      band_r <= band_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // White noise source
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lfsr_r <= `HSP_LFSR_SEED;
      nse_r  <= '0;
    end else begin
      if (take) lfsr_r <= {lfsr_r[18:0], lfsr_r[19] ^ lfsr_r[16]};
      if (st_r == ST_BQ && bq_idx_r == `HSP_NOISE_BQ) begin
        nse_r <= i_cfg.noise_en ? (bq_out >>> i_cfg.noise_shift) : '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  hsp_smp_t nclip;
  assign nclip = -i_cfg.clip_level;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r     <= ST_IDLE;
      bq_idx_r <= 4'h0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (take) begin
            st_r     <= ST_BQ;
            bq_idx_r <= `HSP_NOISE_BQ;
          end
        end
        ST_BQ: begin
          unique case (bq_idx_r)
            `HSP_NOISE_BQ: bq_idx_r <= 4'h0;
            4'h1: begin
              st_r     <= ST_COMB;
              bq_idx_r <= 4'h2;
            end
            4'h5: begin
              st_r     <= ST_CHAN;
              bq_idx_r <= 4'h6;
            end
            4'h7: begin
              st_r     <= ST_GAIN;
              bq_idx_r <= 4'h8;
            end
            4'h9: st_r <= ST_CLIP;
            default: bq_idx_r <= bq_idx_r + 4'h1;
          endcase
        end
        ST_COMB: st_r <= ST_BQ;
        ST_CHAN: st_r <= ST_BQ;
        ST_GAIN: st_r <= ST_VOL;
        ST_VOL:  st_r <= ST_BQ;
        ST_CLIP: st_r <= ST_PUSH;
        ST_PUSH: begin
          if (fifo_rdy) st_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      acc_r   <= '0;
      front_r <= '0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (take) begin
            acc_r   <= sec_in;
            front_r <= widen(i_adc.front);
          end
        end
        ST_BQ: begin
          if (bq_idx_r != `HSP_NOISE_BQ) acc_r <= bq_out;
        end
        ST_COMB: acc_r <= comb_v;
        ST_CHAN: acc_r <= chan_v;
        ST_GAIN: acc_r <= mulq(acc_r, i_cfg.wb_gain);
        ST_VOL: begin
          acc_r <= mulq(i_cfg.noise_post ? acc_r : sat(40'(acc_r) + 40'(nse_r)), i_cfg.volume);
        end
        ST_CLIP: begin
          if (i_cfg.noise_post) begin
            acc_r <= sat(40'(acc_r) + 40'(nse_r));
          end
        end
        ST_PUSH: begin
          if (acc_r > i_cfg.clip_level) acc_r <= i_cfg.clip_level;
          else if (acc_r < nclip) acc_r <= nclip;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output buffer towards the D/A stage
  hsp_smp_t clip_v;
  assign clip_v = (acc_r > i_cfg.clip_level) ? i_cfg.clip_level : (acc_r < nclip) ? nclip : acc_r;

  hsp_fifo #(
    .WIDTH (`HSP_SMP_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (st_r == ST_PUSH),
    .o_in_ready  (fifo_rdy),
    .i_in_data   (clip_v),
    .o_out_valid (fifo_vld),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_dat)
  );

  assign fifo_pop = fifo_vld && (!dac_valid_r || i_dac_ready);

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dac_valid_r <= 1'b0;
      dac_data_r  <= '0;
    end else if (!dac_valid_r || i_dac_ready) begin
      dac_valid_r <= fifo_vld;
      dac_data_r  <= fifo_dat;
    end
  end

  assign o_dac_valid = dac_valid_r;
  assign o_dac_data  = dac_data_r;
  assign o_overrun   = overrun_r;
endmodule // hsp_signal_path
`default_nettype wire
